// >>> core/dac_cfg_pkg.sv
/*
  Constants, field layout and carrier types for the converter front-end control registers.
  Assumes one 25 MHz core clock and a host on the serial programming pins, sampled synchronously.
*/
package dac_cfg_pkg;

  localparam logic [6:0] ADDR_PATH_CONTROL = 7'h00;
  localparam logic [6:0] ADDR_INPUT_CHECK_CONTROL = 7'h01;
  localparam logic [6:0] ADDR_SHUTDOWN_MIXER_FORMAT = 7'h02;
  localparam logic [6:0] ADDR_OUTPUT_SCALE_TRANSMIT = 7'h03;
  localparam logic [6:0] ADDR_PATTERN_CHECK_RESULT = 7'h04;

  localparam logic [15:0] RST_PATH_CONTROL = 16'h049C;
  localparam logic [15:0] RST_INPUT_CHECK_CONTROL = 16'h040E;
  localparam logic [15:0] RST_SHUTDOWN_MIXER_FORMAT = 16'h7000;
  localparam logic [15:0] RST_OUTPUT_SCALE_TRANSMIT = 16'hF000;
  localparam logic [15:0] RST_PATTERN_CHECK_RESULT = 16'h0000;

  // Writable bits; reserved ones stay zero
  localparam logic [15:0] MASK_PATH_CONTROL = 16'hFF9F;
  localparam logic [15:0] MASK_INPUT_CHECK_CONTROL = 16'h9FFE;
  localparam logic [15:0] MASK_SHUTDOWN_MIXER_FORMAT = 16'h70FA;
  localparam logic [15:0] MASK_OUTPUT_SCALE_TRANSMIT = 16'hF001;

  // path_control fields
  localparam int B_OFFSET_PAIR1 = 15;
  localparam int B_OFFSET_PAIR2 = 14;
  localparam int B_PHGAIN_PAIR1 = 13;
  localparam int B_PHGAIN_PAIR2 = 12;
  localparam int B_INTERP_LSB = 8;
  localparam int B_FIFO_ENABLE = 7;
  localparam int B_ALARM_OUT_ENABLE = 4;
  localparam int B_ALARM_OUT_POLARITY = 3;
  localparam int B_DIVIDER_SYNC = 2;
  localparam int B_DROOP_PAIR1 = 1;
  localparam int B_DROOP_PAIR2 = 0;
  // input_check_control fields
  localparam int B_PATTERN_CHECK = 15;
  localparam int B_AUTO_CLEAR = 12;
  localparam int B_PARITY_ODD = 11;
  localparam int B_PARITY_ENABLE = 10;
  localparam int B_PARITY_DUAL = 9;
  localparam int B_REV_INTERFACE = 8;
  localparam int B_INVERT_A = 7;
  localparam int B_TWO_APART = 3;
  localparam int B_ONE_APART = 2;
  localparam int B_COLLISION = 1;
  // shutdown_mixer_format fields
  localparam int B_CONV_CLK_GONE = 14;
  localparam int B_INPUT_CLK_GONE = 13;
  localparam int B_COLLISION_GONE = 12;
  localparam int B_FOUR_WIRE = 7;
  localparam int B_MIXER_ENABLE = 6;
  localparam int B_MIXER_GAIN = 5;
  localparam int B_NCO_ENABLE = 4;
  localparam int B_REV_BUS = 3;
  localparam int B_TWOS = 1;
  // output_scale_transmit fields
  localparam int B_COARSE_LSB = 12;
  localparam int B_SW_TRANSMIT = 0;

  localparam logic [3:0] INTERP_1X = 4'h0;
  localparam logic [3:0] INTERP_2X = 4'h1;
  localparam logic [3:0] INTERP_4X = 4'h2;
  localparam logic [3:0] INTERP_8X = 4'h4;
  localparam logic [3:0] INTERP_16X = 4'h8;

  localparam logic [6:0] GOOD_RUN_LENGTH = 7'h40;
  localparam logic [4:0] SIF_CMD_LAST = 5'h07;
  localparam logic [4:0] SIF_DATA_FIRST = 5'h08;
  localparam logic [4:0] SIF_FRAME_LAST = 5'h17;

  typedef enum logic [1:0] {SIF_IDLE, SIF_CMD, SIF_DATA, SIF_DONE} sif_state_t;

  typedef struct packed {
    logic offset_corr_pair1_enable;
    logic offset_corr_pair2_enable;
    logic phase_gain_corr_pair1_enable;
    logic phase_gain_corr_pair2_enable;
    logic [2:0] interp_log2;
    logic interp_code_valid;
    logic fifo_enable;
    logic droop_comp_pair1_enable;
    logic droop_comp_pair2_enable;
    logic serial_four_wire_select;
    logic mixer_enable;
    logic mixer_gain_6db;
    logic nco_enable;
    logic [4:0] full_scale_steps;
  } config_t;

  typedef struct packed {
    logic sclk;
    logic enable_n;
    logic data_in;
  } sif_in_t;

  typedef struct packed {
    logic data_out;
    logic data_oe;
    logic sdo_out;
    logic sdo_oe;
  } sif_out_t;

endpackage

// >>> core/dac_front_end_config_regs.sv
/*
  Front-end control registers behind the serial programming port, plus the small logic they steer:
  input routing, sample formatting, parity and pattern-check capture, alarm pin and output gating.
  Assumes all pins arrive synchronous to core_clk and sclk is far slower than core_clk.
*/
`timescale 1ns/100ps
module dac_front_end_config_regs import dac_cfg_pkg::*; (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire sif_in_t sif_in,
  output sif_out_t sif_out,
  input wire logic transmit_enable_pin,
  input wire logic sample_strobe_pair,
  input wire logic sync_input_pair,
  input wire logic parity_input_pair,
  input wire logic [3:0][15:0] channel_data_in,
  input wire logic [15:0] pattern_bit_fail,
  input wire logic alarm_level,
  input wire logic converter_clock_lost,
  input wire logic input_clock_lost,
  input wire logic [2:0] fifo_distance,
  output config_t cfg,
  output logic [3:0][15:0] channel_data_out,
  output logic [3:0] parity_error,
  output logic [2:0] fifo_alarm,
  output logic alarm_pin_out,
  output logic alarm_pin_oe,
  output logic divider_sync,
  output logic output_shutdown,
  output logic transmit_active,
  output logic alarm_auto_clear
);

  typedef struct packed {
    sif_state_t sif_state;
    logic sclk_prev;
    logic [4:0] bit_count;
    logic [15:0] shift_in;
    logic read_cmd;
    logic [6:0] addr;
    logic [15:0] shift_out;
    logic [15:0] path_control;
    logic [15:0] input_check_control;
    logic [15:0] shutdown_mixer_format;
    logic [15:0] output_scale_transmit;
    logic [15:0] pattern_check_result;
    logic [6:0] good_count;
    logic auto_clear;
    logic [3:0][15:0] chan_out;
    logic [3:0] parity_err;
  } state_t;

  function automatic logic [15:0] reverse16(input logic [15:0] d);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = d[15 - i];
    end
    return r;
  endfunction

  function automatic logic [15:0] masked_write(input logic [15:0] d, input logic [15:0] m);
    return d & m;
  endfunction

  state_t st;
  state_t next_st;

  logic strobe_role;
  logic sync_role;
  logic parity_role;
  logic sclk_rise;
  logic sclk_fall;
  logic [15:0] sif_word;
  logic write_commit;
  logic [3:0][15:0] chan_fmt;
  logic [3:0] chan_parity;
  logic [3:0] next_parity_err;
  logic good_sample;
  logic [15:0] read_data;

  assign strobe_role = st.input_check_control[B_REV_INTERFACE] ? sync_input_pair : sample_strobe_pair;
  assign sync_role = st.input_check_control[B_REV_INTERFACE] ? parity_input_pair : sync_input_pair;
  assign parity_role = st.input_check_control[B_REV_INTERFACE] ? sample_strobe_pair : parity_input_pair;

  assign sclk_rise = sif_in.sclk & ~st.sclk_prev;
  assign sclk_fall = ~sif_in.sclk & st.sclk_prev;
  assign sif_word = {st.shift_in[14:0], sif_in.data_in};
  assign write_commit = (st.sif_state == SIF_DATA) && sclk_rise && !sif_in.enable_n
    && (st.bit_count == SIF_FRAME_LAST) && !st.read_cmd;

  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_chan
      logic [15:0] ordered;
      logic [15:0] twos;
      assign ordered = st.shutdown_mixer_format[B_REV_BUS] ? reverse16(channel_data_in[c]) : channel_data_in[c];
      assign twos = st.shutdown_mixer_format[B_TWOS] ? ordered : {~ordered[15], ordered[14:0]};
      assign chan_fmt[c] = st.input_check_control[B_INVERT_A - c] ? ~twos : twos;
      assign chan_parity[c] = ^channel_data_in[c];
    end
  endgenerate

  // parity sense and single or dual check
  always_comb begin
    next_parity_err = '0;
    if (st.input_check_control[B_PARITY_ENABLE] && strobe_role) begin
      if (st.input_check_control[B_PARITY_DUAL]) begin
        for (int i = 0; i < 4; i++) begin
          next_parity_err[i] = (chan_parity[i] ^ parity_role) != st.input_check_control[B_PARITY_ODD];
        end
      end else begin
        next_parity_err[0] = (^chan_parity ^ parity_role) != st.input_check_control[B_PARITY_ODD];
      end
    end
  end

  assign good_sample = strobe_role && (next_parity_err == '0) && (pattern_bit_fail == '0);

  always_comb begin
    case (st.addr)
      ADDR_PATH_CONTROL: read_data = st.path_control;
      ADDR_INPUT_CHECK_CONTROL: read_data = st.input_check_control;
      ADDR_SHUTDOWN_MIXER_FORMAT: read_data = st.shutdown_mixer_format;
      ADDR_OUTPUT_SCALE_TRANSMIT: read_data = st.output_scale_transmit;
      ADDR_PATTERN_CHECK_RESULT: read_data = st.pattern_check_result;
      default: read_data = 16'h0000;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.sclk_prev = sif_in.sclk;
    next_st.auto_clear = 1'b0;
    // Serial frame: R/W bit, 7-bit address, 16 data bits, MSB first on rising sclk
    case (st.sif_state)
      SIF_IDLE: begin
        if (!sif_in.enable_n) begin
          next_st.sif_state = SIF_CMD;
          next_st.bit_count = '0;
        end
      end
      SIF_CMD: begin
        if (sclk_rise) begin
          next_st.shift_in = sif_word;
          next_st.bit_count = st.bit_count + 5'h01;
          if (st.bit_count == SIF_CMD_LAST) begin
            next_st.read_cmd = st.shift_in[6];
            next_st.addr = sif_word[6:0];
            next_st.sif_state = SIF_DATA;
          end
        end
      end
      SIF_DATA: begin
        if (sclk_rise) begin
          next_st.shift_in = sif_word;
          next_st.bit_count = st.bit_count + 5'h01;
          if (st.bit_count == SIF_FRAME_LAST) begin
            next_st.sif_state = SIF_DONE;
          end
        end
        // First data bit appears after the command's last rising edge, so the host sees it next rise
        if (sclk_fall && st.read_cmd) begin
          if (st.bit_count == SIF_DATA_FIRST) begin
            next_st.shift_out = read_data;
          end else begin
            next_st.shift_out = {st.shift_out[14:0], 1'b0};
          end
        end
      end
      SIF_DONE: begin
        next_st.sif_state = SIF_DONE;
      end
      default: next_st.sif_state = SIF_IDLE;
    endcase
    // Frame end or abort always returns to idle
    if (sif_in.enable_n) begin
      next_st.sif_state = SIF_IDLE;
    end

    if (write_commit) begin
      case (st.addr)
        ADDR_PATH_CONTROL: next_st.path_control = masked_write(sif_word, MASK_PATH_CONTROL);
        ADDR_INPUT_CHECK_CONTROL: next_st.input_check_control = masked_write(sif_word, MASK_INPUT_CHECK_CONTROL);
        ADDR_SHUTDOWN_MIXER_FORMAT: begin
          next_st.shutdown_mixer_format = masked_write(sif_word, MASK_SHUTDOWN_MIXER_FORMAT);
        end
        ADDR_OUTPUT_SCALE_TRANSMIT: begin
          next_st.output_scale_transmit = masked_write(sif_word, MASK_OUTPUT_SCALE_TRANSMIT);
        end
        default: next_st.path_control = st.path_control;
      endcase
    end

    // a write to the result word clears it; a fresh failure still wins while the checker runs
    if (write_commit && st.addr == ADDR_PATTERN_CHECK_RESULT) begin
      next_st.pattern_check_result = '0;
    end
    if (st.input_check_control[B_PATTERN_CHECK]) begin
      next_st.pattern_check_result = next_st.pattern_check_result | pattern_bit_fail;
    end

    // run of good samples clears alarms
    if (!st.input_check_control[B_AUTO_CLEAR]) begin
      next_st.good_count = '0;
    end else if (strobe_role) begin
      if (!good_sample) begin
        next_st.good_count = '0;
      end else if (st.good_count == GOOD_RUN_LENGTH - 7'h01) begin
        next_st.good_count = '0;
        next_st.auto_clear = 1'b1;
      end else begin
        next_st.good_count = st.good_count + 7'h01;
      end
    end

    if (strobe_role) begin
      next_st.chan_out = chan_fmt;
    end
    next_st.parity_err = next_parity_err;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{sif_state: SIF_IDLE, sclk_prev: 1'b0, bit_count: 5'h00, shift_in: 16'h0000, read_cmd: 1'b0,
        addr: 7'h00, shift_out: 16'h0000, path_control: RST_PATH_CONTROL,
        input_check_control: RST_INPUT_CHECK_CONTROL, shutdown_mixer_format: RST_SHUTDOWN_MIXER_FORMAT,
        output_scale_transmit: RST_OUTPUT_SCALE_TRANSMIT, pattern_check_result: RST_PATTERN_CHECK_RESULT,
        good_count: 7'h00, auto_clear: 1'b0, chan_out: '0, parity_err: 4'h0};
    end else begin
      st <= next_st;
    end
  end

  // width bit picks the read-back pin
  always_comb begin
    sif_out.data_out = st.shift_out[15];
    sif_out.sdo_out = st.shift_out[15];
    sif_out.data_oe = 1'b0;
    sif_out.sdo_oe = 1'b0;
    if (st.sif_state == SIF_DATA && st.read_cmd && !sif_in.enable_n) begin
      sif_out.data_oe = ~st.shutdown_mixer_format[B_FOUR_WIRE];
      sif_out.sdo_oe = st.shutdown_mixer_format[B_FOUR_WIRE];
    end
  end

  always_comb begin
    cfg.offset_corr_pair1_enable = st.path_control[B_OFFSET_PAIR1];
    cfg.offset_corr_pair2_enable = st.path_control[B_OFFSET_PAIR2];
    cfg.phase_gain_corr_pair1_enable = st.path_control[B_PHGAIN_PAIR1];
    cfg.phase_gain_corr_pair2_enable = st.path_control[B_PHGAIN_PAIR2];
    cfg.interp_code_valid = 1'b1;
    case (st.path_control[B_INTERP_LSB +: 4])
      INTERP_1X: cfg.interp_log2 = 3'h0;
      INTERP_2X: cfg.interp_log2 = 3'h1;
      INTERP_4X: cfg.interp_log2 = 3'h2;
      INTERP_8X: cfg.interp_log2 = 3'h3;
      INTERP_16X: cfg.interp_log2 = 3'h4;
      default: begin
        cfg.interp_log2 = 3'h0;
        cfg.interp_code_valid = 1'b0;
      end
    endcase
    cfg.fifo_enable = st.path_control[B_FIFO_ENABLE];
    cfg.droop_comp_pair1_enable = st.path_control[B_DROOP_PAIR1];
    cfg.droop_comp_pair2_enable = st.path_control[B_DROOP_PAIR2];
    cfg.serial_four_wire_select = st.shutdown_mixer_format[B_FOUR_WIRE];
    cfg.mixer_enable = st.shutdown_mixer_format[B_MIXER_ENABLE];
    cfg.mixer_gain_6db = st.shutdown_mixer_format[B_MIXER_GAIN];
    cfg.nco_enable = st.shutdown_mixer_format[B_NCO_ENABLE];
    cfg.full_scale_steps = {1'b0, st.output_scale_transmit[B_COARSE_LSB +: 4]} + 5'h01;
  end

  assign alarm_pin_oe = st.path_control[B_ALARM_OUT_ENABLE];
  assign alarm_pin_out = st.path_control[B_ALARM_OUT_POLARITY] ? alarm_level : ~alarm_level;
  // divider sync from sync source
  assign divider_sync = st.path_control[B_DIVIDER_SYNC] & sync_role;
  assign fifo_alarm = fifo_distance & {st.input_check_control[B_COLLISION],
    st.input_check_control[B_ONE_APART], st.input_check_control[B_TWO_APART]};
  // loss or collision shuts the outputs; masks are the host's duty
  assign output_shutdown = (converter_clock_lost & st.shutdown_mixer_format[B_CONV_CLK_GONE])
    | (input_clock_lost & st.shutdown_mixer_format[B_INPUT_CLK_GONE])
    | (fifo_distance[2] & st.shutdown_mixer_format[B_COLLISION_GONE]);
  // pin or software bit enables, checker overrides
  assign transmit_active = (st.output_scale_transmit[B_SW_TRANSMIT] | transmit_enable_pin)
    & ~st.input_check_control[B_PATTERN_CHECK] & ~output_shutdown;

  assign channel_data_out = st.chan_out;
  assign parity_error = st.parity_err;
  assign alarm_auto_clear = st.auto_clear;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence write_to(logic [6:0] a);
    write_commit && st.addr == a;
  endsequence

  chk_path_write_mask: assert property (write_to(ADDR_PATH_CONTROL) |=>
    st.path_control == ($past(sif_word) & MASK_PATH_CONTROL))
    else $error("path control write not stored with mask");

  chk_scale_write_steps: assert property (write_to(ADDR_OUTPUT_SCALE_TRANSMIT) |=>
    cfg.full_scale_steps == {1'b0, $past(sif_word[15:12])} + 5'h01)
    else $error("full scale steps wrong after write");

  chk_result_set_wins: assert property ((write_commit && st.addr == ADDR_PATTERN_CHECK_RESULT
    && st.input_check_control[B_PATTERN_CHECK]) |=> st.pattern_check_result == $past(pattern_bit_fail))
    else $error("result clear lost a fresh failure");

  chk_checker_silences: assert property (st.input_check_control[B_PATTERN_CHECK]
    |-> !transmit_active)
    else $error("output active while pattern checker runs");

  chk_transmit_either: assert property ((transmit_enable_pin || st.output_scale_transmit[0])
    && !st.input_check_control[B_PATTERN_CHECK] && !output_shutdown |-> transmit_active)
    else $error("transmit not enabled by pin or bit");

  chk_auto_clear_run: assert property (alarm_auto_clear |->
    $past(st.good_count) == GOOD_RUN_LENGTH - 7'h01 && $past(good_sample))
    else $error("auto clear not after 64 good samples");

  chk_parity_single: assert property (strobe_role && st.input_check_control[B_PARITY_ENABLE]
    && !st.input_check_control[B_PARITY_DUAL] |=> parity_error[0] ==
    ($past(^channel_data_in ^ parity_role) != $past(st.input_check_control[B_PARITY_ODD])))
    else $error("single parity result wrong");

  chk_rev_rotation: assert property (st.input_check_control[B_REV_INTERFACE]
    |-> strobe_role == sync_input_pair && parity_role == sample_strobe_pair)
    else $error("interface rotation wrong");

  chk_invert_channel: assert property (strobe_role && st.input_check_control[B_INVERT_A]
    && st.shutdown_mixer_format[B_TWOS] && !st.shutdown_mixer_format[B_REV_BUS]
    |=> channel_data_out[0] == ~$past(channel_data_in[0]))
    else $error("channel A not complemented");

  chk_alarm_pin_drive: assert property (alarm_pin_oe == st.path_control[B_ALARM_OUT_ENABLE]
    && (alarm_pin_out == (alarm_level == st.path_control[B_ALARM_OUT_POLARITY])))
    else $error("alarm pin drive or polarity wrong");

  chk_shutdown_clock: assert property (converter_clock_lost
    && st.shutdown_mixer_format[B_CONV_CLK_GONE] |-> output_shutdown && !transmit_active)
    else $error("clock loss did not shut output");

endmodule

// >>> bench/sif_host_model.sv
/*
  Host model for the serial programming port: read bit, 7-bit address, 16 data bits, MSB first.
  Assumes core_clk is the device clock; each sclk phase lasts two core cycles.
*/
`timescale 1ns/100ps
module sif_host_model import dac_cfg_pkg::*; (
  input wire logic core_clk,
  input wire sif_out_t sif_out,
  input wire logic four_wire,
  output sif_in_t sif_in
);
  logic sclk = 1'b0;
  logic frame_n = 1'b1;
  logic host_bit = 1'b0;
  // Shared line follows the device while it drives
  assign sif_in = '{sclk: sclk, enable_n: frame_n, data_in: sif_out.data_oe ? sif_out.data_out : host_bit};
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wdata, output logic [15:0] rdata);
    logic [23:0] frame;
    frame = {rd, addr, wdata};
    rdata = 16'h0000;
    @(negedge core_clk);
    frame_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // Released line toggles so a stale bit never passes for data
      host_bit = (rd && i < 16) ? ~host_bit : frame[i];
      repeat (2) @(negedge core_clk);
      // Undriven pin reads inverted so a missing enable cannot pass
      if (i < 16) begin
        rdata[i] = four_wire ? (sif_out.sdo_oe ? sif_out.sdo_out : ~sif_out.sdo_out)
          : (sif_out.data_oe ? sif_out.data_out : ~sif_out.data_out);
      end
      sclk = 1'b1;
      repeat (2) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (2) @(negedge core_clk);
    frame_n = 1'b1;
    host_bit = ~host_bit;
    @(negedge core_clk);
  endtask
endmodule

// >>> bench/tb_dac_front_end_config_regs.sv
/*
  Self-checking bench for the front-end control registers, driven through the serial host model.
  Assumes a 25 MHz core clock and inputs changed on its falling edge.
*/
`timescale 1ns/100ps
module tb_dac_front_end_config_regs import dac_cfg_pkg::*;;
  logic core_clk, arst_n = 1'b0, transmit_enable_pin = 1'b0, sample_strobe_pair = 1'b0;
  logic sync_input_pair = 1'b0, parity_input_pair = 1'b0, alarm_level = 1'b0;
  logic converter_clock_lost = 1'b0, input_clock_lost = 1'b0;
  logic [3:0][15:0] channel_data_in = '0;
  logic [15:0] pattern_bit_fail = '0;
  logic [2:0] fifo_distance = '0;
  sif_in_t sif_in;
  sif_out_t sif_out;
  config_t cfg;
  logic [3:0][15:0] channel_data_out;
  logic [3:0] parity_error, pe;
  logic [2:0] fifo_alarm;
  logic alarm_pin_out, alarm_pin_oe, divider_sync, output_shutdown, transmit_active, alarm_auto_clear;
  logic [15:0] rd;
  logic [15:0] rv [5] = '{16'h049C, 16'h040E, 16'h7000, 16'hF000, 16'h0000};
  logic [15:0] mk [6] = '{16'hFF9F, 16'h9FFE, 16'h70FA, 16'hF001, 16'h0000, 16'h0000};
  int n_fail = 0, n_checks = 0, pulses;
  dac_front_end_config_regs dac_front_end_config_regs_inst (.core_clk, .arst_n, .sif_in, .sif_out,
    .transmit_enable_pin, .sample_strobe_pair, .sync_input_pair, .parity_input_pair, .channel_data_in,
    .pattern_bit_fail, .alarm_level, .converter_clock_lost, .input_clock_lost, .fifo_distance, .cfg,
    .channel_data_out, .parity_error, .fifo_alarm, .alarm_pin_out, .alarm_pin_oe, .divider_sync,
    .output_shutdown, .transmit_active, .alarm_auto_clear);
  sif_host_model sif_host_model_inst (.core_clk, .sif_out, .four_wire(cfg.serial_four_wire_select), .sif_in);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    sif_host_model_inst.xfer(1'b0, a, d, rd);
  endtask
  task automatic rg(input logic [6:0] a);
    sif_host_model_inst.xfer(1'b1, a, 16'h0000, rd);
  endtask
  // Parity result lands one edge after the strobe and clears on the next
  task automatic strobe;
    sample_strobe_pair = 1'b1;
    cyc(1);
    sample_strobe_pair = 1'b0;
    pe = parity_error;
    cyc(1);
    pe = pe | parity_error;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      rg(7'(i));
      chk(rd, rv[i]);
    end
    chk({cfg.interp_log2, cfg.interp_code_valid, cfg.fifo_enable}, 5'h0F);
    chk({alarm_pin_oe, cfg.full_scale_steps}, 6'h30);
  endtask
  task automatic t_masks;
    for (int i = 0; i < 6; i++) wr(7'(i), 16'hFFFF);
    for (int i = 0; i < 6; i++) begin
      rg(7'(i));
      chk(rd, mk[i]);
    end
    chk({cfg[19:16], cfg[10:9], cfg[7:5], cfg.interp_code_valid}, 10'h3FE);
    for (int i = 0; i < 4; i++) wr(7'(i), rv[i]);
    chk(cfg.serial_four_wire_select, 1'b0);
  endtask
  task automatic t_interp;
    logic [3:0] code [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_PATH_CONTROL, {4'h0, code[i], 8'h9C});
      chk({cfg.interp_log2, cfg.interp_code_valid}, {3'(i), 1'b1});
    end
    wr(ADDR_PATH_CONTROL, RST_PATH_CONTROL);
  endtask
  task automatic t_pins;
    alarm_level = 1'b1;
    sync_input_pair = 1'b1;
    cyc(1);
    chk({alarm_pin_oe, alarm_pin_out, divider_sync}, 3'h7);
    wr(ADDR_PATH_CONTROL, 16'h0494);
    chk({alarm_pin_oe, alarm_pin_out}, 2'h2);
    wr(ADDR_PATH_CONTROL, 16'h0480);
    chk({alarm_pin_oe, divider_sync}, 2'h0);
    wr(ADDR_PATH_CONTROL, RST_PATH_CONTROL);
    sync_input_pair = 1'b0;
    parity_input_pair = 1'b1;
    wr(ADDR_INPUT_CHECK_CONTROL, 16'h050E);
    chk(divider_sync, 1'b1);
    parity_input_pair = 1'b0;
    transmit_enable_pin = 1'b1;
    wr(ADDR_INPUT_CHECK_CONTROL, RST_INPUT_CHECK_CONTROL);
    chk(transmit_active, 1'b1);
    transmit_enable_pin = 1'b0;
    wr(ADDR_OUTPUT_SCALE_TRANSMIT, 16'h0001);
    chk({transmit_active, cfg.full_scale_steps}, 6'h21);
    wr(ADDR_INPUT_CHECK_CONTROL, 16'h840E);
    chk(transmit_active, 1'b0);
    wr(ADDR_INPUT_CHECK_CONTROL, RST_INPUT_CHECK_CONTROL);
    wr(ADDR_OUTPUT_SCALE_TRANSMIT, RST_OUTPUT_SCALE_TRANSMIT);
    chk(transmit_active, 1'b0);
  endtask
  task automatic t_gates;
    converter_clock_lost = 1'b1;
    cyc(1);
    chk(output_shutdown, 1'b1);
    wr(ADDR_SHUTDOWN_MIXER_FORMAT, 16'h3000);
    chk(output_shutdown, 1'b0);
    input_clock_lost = 1'b1;
    fifo_distance = 3'h7;
    wr(ADDR_SHUTDOWN_MIXER_FORMAT, 16'h1000);
    chk({output_shutdown, fifo_alarm}, 4'hF);
    wr(ADDR_INPUT_CHECK_CONTROL, 16'h0408);
    chk(fifo_alarm, 3'h1);
    converter_clock_lost = 1'b0;
    input_clock_lost = 1'b0;
    fifo_distance = 3'h0;
  endtask
  task automatic t_samples;
    channel_data_in = {16'h0000, 16'h0000, 16'h0001, 16'h1234};
    strobe;
    chk({channel_data_out, pe}, {64'h8000_8000_8001_9234, 4'h0});
    parity_input_pair = 1'b1;
    strobe;
    chk(pe[0], 1'b1);
    wr(ADDR_SHUTDOWN_MIXER_FORMAT, 16'h700A);
    wr(ADDR_INPUT_CHECK_CONTROL, 16'h0C8E);
    strobe;
    chk({channel_data_out, pe}, {64'h0000_0000_8000_D3B7, 4'h0});
    // Dual bit alone checks nothing
    wr(ADDR_INPUT_CHECK_CONTROL, 16'h020E);
    strobe;
    chk(pe, 4'h0);
    wr(ADDR_INPUT_CHECK_CONTROL, 16'h0E0E);
    strobe;
    chk(pe, 4'h3);
    parity_input_pair = 1'b0;
    wr(ADDR_INPUT_CHECK_CONTROL, 16'h1C8E);
    // Bad strobe first so the good run starts from zero
    strobe;
    parity_input_pair = 1'b1;
    pulses = 0;
    sample_strobe_pair = 1'b1;
    repeat (63) begin
      cyc(1);
      pulses += alarm_auto_clear;
    end
    cyc(1);
    sample_strobe_pair = 1'b0;
    chk({pulses[7:0], alarm_auto_clear}, 9'h001);
    wr(ADDR_SHUTDOWN_MIXER_FORMAT, RST_SHUTDOWN_MIXER_FORMAT);
  endtask
  task automatic t_result;
    wr(ADDR_INPUT_CHECK_CONTROL, RST_INPUT_CHECK_CONTROL);
    pattern_bit_fail = 16'h00FF;
    cyc(1);
    pattern_bit_fail = 16'hA501;
    rg(ADDR_PATTERN_CHECK_RESULT);
    chk(rd, 16'h0000);
    wr(ADDR_INPUT_CHECK_CONTROL, 16'h840E);
    cyc(1);
    pattern_bit_fail = 16'h0000;
    rg(ADDR_PATTERN_CHECK_RESULT);
    chk(rd, 16'hA501);
    wr(ADDR_PATTERN_CHECK_RESULT, 16'h0000);
    rg(ADDR_PATTERN_CHECK_RESULT);
    chk(rd, 16'h0000);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    t_reset;
    t_masks;
    t_interp;
    t_pins;
    t_gates;
    t_samples;
    t_result;
    complete_run;
  end
  // About 5200 cycles expected; generous margin
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    complete_run;
  end
endmodule
